// ### core/fdr_pkg.sv
// Purpose: Shared constants and types for the floppy host register bank
// Assumes: APB with 32-bit data; register index times four is byte address
// Notes: Indices 2, 3, 4, 5, 7 follow the controller map; 8 upward are local
`default_nettype none
package fdr_pkg;
	// Register indices (byte address is index times four)
	localparam logic [5:0] IDX_DIGITAL_OUT = 6'h02;
	localparam logic [5:0] IDX_TAPE = 6'h03;
	localparam logic [5:0] IDX_MAIN_STAT = 6'h04;
	localparam logic [5:0] IDX_FIFO = 6'h05;
	localparam logic [5:0] IDX_SENSE = 6'h07;
	localparam logic [5:0] IDX_DRIVE_TYPE = 6'h08;
	localparam logic [5:0] IDX_MEDIA_BOOT = 6'h09;
	localparam logic [5:0] IDX_LDEV0_RATE = 6'h0a;
	localparam logic [5:0] IDX_SYS_MODE = 6'h0b;
	localparam logic [5:0] IDX_STATUS_VIEW = 6'h0c;

	// Rate, precompensation and digital output control fields
	localparam int DR_SWRESET_BIT = 7;
	localparam int DR_PWRDN_BIT = 6;
	localparam int DR_PRECOMP_HI = 4;
	localparam int DR_PRECOMP_LO = 2;
	localparam int CC_NO_PRECOMP_FLAG_BIT = 2;
	localparam int DOR_DMA_BIT = 3;

	// Rate field codes
	localparam logic [1:0] RATE_500K = 2'h0;
	localparam logic [1:0] RATE_300K = 2'h1;
	localparam logic [1:0] RATE_250K = 2'h2;
	localparam logic [1:0] RATE_1M = 2'h3;
	localparam logic [1:0] TAPE_EXT_2M = 2'h2;

	// Precompensation codes and step counts (one step 41.67 or 20.8 ns)
	localparam logic [2:0] PRECOMP_DEFAULT = 3'h0;
	localparam logic [2:0] PRECOMP_OFF = 3'h7;
	localparam logic [2:0] PRECOMP_DEF_STD = 3'h3;
	localparam logic [2:0] PRECOMP_DEF_FAST = 3'h1;
	localparam logic [2:0] PRECOMP_NONE = 3'h0;

	// Status byte zero interrupt code field
	localparam int ST0_IC_HI = 7;
	localparam int ST0_IC_LO = 6;
	localparam logic [1:0] IC_READY_CHANGED = 2'h3;

	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	typedef enum logic [1:0] {
		MODE_BASELINE_AT = 2'b00,
		MODE_ALT_SYSTEM = 2'b01,
		MODE_ALT_VARIANT = 2'b10
	} fdr_mode_t;

	typedef enum logic [2:0] {
		XFER_250K = 3'b000,
		XFER_300K = 3'b001,
		XFER_500K = 3'b010,
		XFER_1M = 3'b011,
		XFER_2M = 3'b100
	} fdr_rate_t;
endpackage : fdr_pkg
`default_nettype wire

// ### core/fdr_host_regs.sv
// Purpose: Host register bank of a floppy controller behind an APB slave
// Assumes: Command engine and drive pins sit outside; one clock clk_sys
// Notes: Data register path holds an 8-deep FIFO toward the command engine
`default_nettype none

// Plain FIFO, flip-flop storage indexed by pointers
module fdr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys, // System clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic flush, // Drop all entries
	input wire logic in_valid, // Write request
	input wire logic [WIDTH-1:0] in_data, // Write data
	output logic in_ready, // Space available
	output logic out_valid, // Entry available
	output logic [WIDTH-1:0] out_data, // Oldest entry
	input wire logic out_ready // Drain side accepts
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
	localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [CW-1:0] count;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// Flags straight from the occupancy count
	assign in_ready = (count != FULL_COUNT);
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];

	// Pointer wrap at depth, not at a power of two
	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		bump = (p == LAST_PTR) ? '0 : p + 1'b1;
	endfunction : bump

	// Storage written only on an accepted push
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Pointers and count
	always_ff @(posedge clk_sys) begin
		if (!rst_n || flush) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= bump(wr_ptr);
			end
			if (pop) begin
				rd_ptr <= bump(rd_ptr);
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule : fdr_fifo

module fdr_host_regs
	import fdr_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int FIFO_DEPTH = 8
) (
	input wire logic clk_sys, // System clock, 10 MHz
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction, high is write
	input wire logic [ADDR_W-1:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire logic [7:0] main_status, // Main status from command engine
	input wire logic disk_changed_n, // Disk change input, active low
	input wire logic [7:0] result_data, // Result byte from engine
	input wire logic result_valid, // Result byte available
	output logic result_ready, // Result byte consumed, one pulse
	output logic [7:0] cmd_data, // Command byte toward engine
	output logic cmd_valid, // Command byte available
	input wire logic cmd_ready, // Engine takes command byte
	input wire logic cfg_strobe, // Configure command executed, pulse
	input wire logic cfg_fifo_on, // FIFO setting of configure command
	input wire logic status_load, // Load a status byte, pulse
	input wire logic [1:0] status_index, // Which status byte to load
	input wire logic [7:0] status_value, // Status byte value
	input wire logic ready_change_abort, // Ready changed during command
	output logic soft_reset, // Controller software reset, pulse
	output logic power_down, // Power-down mode
	output logic reduced_write_current_n, // Reduced write current, low
	output fdr_rate_t xfer_rate, // Effective transfer rate
	output logic fm_illegal, // FM not allowed at this rate
	output logic [2:0] precomp_steps, // Precomp delay in steps
	output logic precomp_fine_step, // Steps are 20.8 ns, else 41.67 ns
	output logic [1:0] tape_drive_sel, // Tape drive number, 0 is none
	output logic [1:0] drive_select, // Selected drive
	output logic dma_gate, // DMA gate from digital output reg
	output logic fifo_enabled // Data FIFO operation enabled
);
	localparam int IW = ADDR_W - 2;

	// Register state
	logic [7:0] digital_out;
	logic [7:0] drive_type_config_reg;
	logic [7:0] media_boot_config_reg;
	logic [1:0] tape_rate_ext;
	fdr_mode_t sys_mode;
	logic [1:0] rate_field;
	logic [2:0] write_precomp_select;
	logic no_precomp_flag;
	logic [7:0] status_stack [4];
	logic [1:0] status_ptr;
	logic [7:0] cmd_q_data;
	logic cmd_q_valid;
	logic cmd_q_in_ready;

	// Address decode
	wire [IW-1:0] reg_index = paddr[ADDR_W-1:2];
	wire aligned = (paddr[1:0] == 2'b00);
	function automatic logic hit(input logic [IW-1:0] i,
			input logic [5:0] r);
		hit = (i == IW'(r));
	endfunction : hit
	wire hit_dor = hit(reg_index, IDX_DIGITAL_OUT);
	wire hit_tape = hit(reg_index, IDX_TAPE);
	wire hit_msr = hit(reg_index, IDX_MAIN_STAT);
	wire hit_fifo = hit(reg_index, IDX_FIFO);
	wire hit_sense = hit(reg_index, IDX_SENSE);
	wire hit_dtype = hit(reg_index, IDX_DRIVE_TYPE);
	wire hit_media = hit(reg_index, IDX_MEDIA_BOOT);
	wire hit_ldev0 = hit(reg_index, IDX_LDEV0_RATE);
	wire hit_mode = hit(reg_index, IDX_SYS_MODE);
	wire hit_sview = hit(reg_index, IDX_STATUS_VIEW);
	wire mapped = aligned && (hit_dor || hit_tape || hit_msr || hit_fifo ||
		hit_sense || hit_dtype || hit_media || hit_ldev0 || hit_mode ||
		hit_sview);

	// Bus handshake; pready is a flop, so every access waits at least one cycle
	wire access = psel && penable;
	wire done = access && pready;
	wire wr_done = done && pwrite && mapped;
	wire rd_done = done && !pwrite && mapped;
	wire [7:0] wbyte = pwdata[7:0];

	// Host bytes stall while the queue cannot take them
	wire fifo_has_room = cmd_q_in_ready && (fifo_enabled || !cmd_q_valid);
	wire can_finish = !(pwrite && aligned && hit_fifo) || fifo_has_room;
	wire cmd_push = wr_done && hit_fifo;

	// Derived rate state
	wire tape_2m = (rate_field == RATE_300K) && (tape_rate_ext == TAPE_EXT_2M);
	wire high_density_n = (rate_field == RATE_300K) ||
		(rate_field == RATE_250K);
	wire [1:0] last_drive = digital_out[1:0];
	wire [1:0] dtype_pair = drive_type_config_reg[{last_drive, 1'b0} +: 2];

	// Tape register view
	wire [7:0] tape_view = {media_boot_config_reg[3:2],
		dtype_pair, media_boot_config_reg[1:0], tape_drive_sel};

	// Input sense view per system mode; baseline drives bit 7 only,
	// the lanes the old bus left floating read back as zero here
	wire [7:0] sense_at = {~disk_changed_n, 7'b000_0000};
	wire [7:0] sense_alt = {~disk_changed_n, 4'b1111, rate_field,
		high_density_n};
	wire [7:0] sense_var = {disk_changed_n, 3'b111, dma_gate,
		no_precomp_flag, rate_field};
	logic [7:0] sense_view;
	always_comb begin
		case (sys_mode)
			MODE_ALT_SYSTEM: sense_view = sense_alt;
			MODE_ALT_VARIANT: sense_view = sense_var;
			default: sense_view = sense_at;
		endcase
	end

	// Data register read: pending result first, else the status stack
	wire [7:0] fifo_view = result_valid ? result_data :
		status_stack[status_ptr];

	// Read mux
	logic [7:0] rd_byte;
	always_comb begin
		rd_byte = BYTE_ZERO;
		if (hit_tape) rd_byte = tape_view;
		if (hit_msr) rd_byte = main_status;
		if (hit_fifo) rd_byte = fifo_view;
		if (hit_sense) rd_byte = sense_view;
		if (hit_dtype) rd_byte = drive_type_config_reg;
		if (hit_media) rd_byte = media_boot_config_reg;
		if (hit_ldev0) rd_byte = {6'b00_0000, tape_rate_ext};
		if (hit_mode) rd_byte = {6'b00_0000, sys_mode};
		if (hit_sview) rd_byte = {6'b00_0000, status_ptr};
	end

	// APB answer registers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pready <= 1'b0;
			prdata <= WORD_ZERO;
			pslverr <= 1'b0;
		end else begin
			pready <= access && !pready && can_finish;
			prdata <= (pwrite || !mapped) ? WORD_ZERO : {24'h00_0000, rd_byte};
			pslverr <= access && !pready && !mapped;
		end
	end

	// Precompensation steps; fine step unit at the tape rate
	logic [2:0] next_steps;
	always_comb begin
		case (write_precomp_select)
			PRECOMP_OFF: next_steps = PRECOMP_NONE;
			PRECOMP_DEFAULT: next_steps = (tape_2m || rate_field == RATE_1M) ?
				PRECOMP_DEF_FAST : PRECOMP_DEF_STD;
			default: next_steps = write_precomp_select;
		endcase
	end

	// Effective transfer rate
	logic [2:0] next_rate;
	always_comb begin
		case (rate_field)
			RATE_500K: next_rate = XFER_500K;
			RATE_300K: next_rate = tape_2m ? XFER_2M : XFER_300K;
			RATE_250K: next_rate = XFER_250K;
			default: next_rate = XFER_1M;
		endcase
	end

	// Registered outputs derived from control state
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			xfer_rate <= XFER_500K;
			reduced_write_current_n <= 1'b1;
			fm_illegal <= 1'b0;
			precomp_steps <= PRECOMP_DEF_STD;
			precomp_fine_step <= 1'b0;
			dma_gate <= 1'b0;
			drive_select <= 2'b00;
		end else begin
			xfer_rate <= fdr_rate_t'(next_rate);
			reduced_write_current_n <= (rate_field == RATE_500K) ||
				(rate_field == RATE_1M);
			fm_illegal <= (rate_field == RATE_1M);
			precomp_steps <= next_steps;
			precomp_fine_step <= tape_2m;
			dma_gate <= digital_out[DOR_DMA_BIT];
			drive_select <= last_drive;
		end
	end

	// Host-written control registers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			digital_out <= BYTE_ZERO;
			drive_type_config_reg <= BYTE_ZERO;
			media_boot_config_reg <= BYTE_ZERO;
			tape_rate_ext <= 2'b00;
			sys_mode <= MODE_BASELINE_AT;
			tape_drive_sel <= 2'b00;
		end else if (wr_done) begin
			if (hit_dor) digital_out <= wbyte;
			if (hit_dtype) drive_type_config_reg <= wbyte;
			if (hit_media) media_boot_config_reg <= wbyte;
			if (hit_ldev0) tape_rate_ext <= wbyte[1:0];
			if (hit_mode && wbyte[1:0] != 2'b11) begin
				sys_mode <= fdr_mode_t'(wbyte[1:0]);
			end
			if (hit_tape) tape_drive_sel <= wbyte[1:0];
		end
	end

	// Rate and precomp; whichever register is written last wins
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rate_field <= RATE_500K;
			write_precomp_select <= PRECOMP_DEFAULT;
			power_down <= 1'b0;
			no_precomp_flag <= 1'b0;
			soft_reset <= 1'b0;
		end else begin
			soft_reset <= wr_done && hit_msr && wbyte[DR_SWRESET_BIT];
			if (wr_done && hit_msr) begin
				rate_field <= wbyte[1:0];
				write_precomp_select <= wbyte[DR_PRECOMP_HI:DR_PRECOMP_LO];
				power_down <= wbyte[DR_PWRDN_BIT];
			end else if (wr_done && hit_sense) begin
				rate_field <= wbyte[1:0];
				if (sys_mode == MODE_ALT_VARIANT) begin
					no_precomp_flag <= wbyte[CC_NO_PRECOMP_FLAG_BIT];
				end
			end
		end
	end

	// FIFO enable: only the configure command or a reset moves it
	always_ff @(posedge clk_sys) begin
		if (!rst_n || soft_reset) begin
			fifo_enabled <= 1'b0;
		end else if (cfg_strobe) begin
			fifo_enabled <= cfg_fifo_on;
		end
	end

	// Result consumption, one pulse per data-register read of a result
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			result_ready <= 1'b0;
		end else begin
			result_ready <= rd_done && hit_fifo && result_valid;
		end
	end

	// Status stack; abort code set wins over a same-cycle load
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_stat
			always_ff @(posedge clk_sys) begin
				if (!rst_n || soft_reset) begin
					status_stack[gi] <= BYTE_ZERO;
				end else begin
					if (status_load && status_index == 2'(gi)) begin
						status_stack[gi] <= status_value;
					end
					if (gi == 0 && ready_change_abort) begin
						status_stack[gi][ST0_IC_HI:ST0_IC_LO] <= IC_READY_CHANGED;
					end
				end
			end
		end
	endgenerate

	// Only one status byte is presented; each data-register read with no result pending moves to the next
	always_ff @(posedge clk_sys) begin
		if (!rst_n || soft_reset || status_load) begin
			status_ptr <= 2'b00;
		end else if (rd_done && hit_fifo && !result_valid) begin
			status_ptr <= status_ptr + 2'b01;
		end
	end

	// Command bytes queue toward the engine; engine stall fills it
	fdr_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_cmd_fifo (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.flush(soft_reset),
		.in_valid(cmd_push),
		.in_data(wbyte),
		.in_ready(cmd_q_in_ready),
		.out_valid(cmd_q_valid),
		.out_data(cmd_q_data),
		.out_ready(cmd_ready)
	);
	assign cmd_valid = cmd_q_valid;
	assign cmd_data = cmd_q_data;
endmodule : fdr_host_regs
`default_nettype wire

// ### tb/fdr_regs_monitor.sv
// Purpose: Port checks for the floppy host register bank
// Assumes: One clock, synchronous active-low reset
// Notes: Bound from the bench top file
`default_nettype none
module fdr_regs_monitor
	import fdr_pkg::*;
(
	input wire logic clk_sys, // Clock
	input wire logic rst_n, // Reset
	input wire logic psel, // Select
	input wire logic penable, // Access
	input wire logic pwrite, // Direction
	input wire logic [7:0] paddr, // Address
	input wire logic [31:0] pwdata, // Write data
	input wire logic pready, // Ready
	input wire logic soft_reset, // Soft reset
	input wire logic power_down, // Power-down
	input wire logic reduced_write_current_n, // Write current
	input wire fdr_rate_t xfer_rate, // Rate
	input wire logic fm_illegal, // FM illegal
	input wire logic precomp_fine_step, // Fine step
	input wire logic fifo_enabled // FIFO on
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Completed write to the shared rate offset
	wire dr_wr = psel && penable && pready && pwrite &&
		paddr == {IDX_MAIN_STAT, 2'b00};
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_rwc_tracks_rate: assert property (
		reduced_write_current_n == (xfer_rate inside {XFER_500K, XFER_1M}))
		else $error("write current wrong");
	a_fm_at_fast: assert property (
		fm_illegal == (xfer_rate == XFER_1M))
		else $error("fm flag wrong");
	a_fine_step_tape: assert property (
		precomp_fine_step == (xfer_rate == XFER_2M))
		else $error("fine step wrong");
	a_soft_from_write: assert property ($rose(soft_reset) |->
		$past(dr_wr && pwdata[7]) || $past(dr_wr && pwdata[7], 2))
		else $error("soft reset without write");
	a_soft_one_pulse: assert property (
		soft_reset |=> !soft_reset)
		else $error("soft reset too long");
	a_soft_clears_fifo: assert property (
		soft_reset |-> ##[0:2] !fifo_enabled)
		else $error("fifo kept after soft reset");
	a_pwrdn_by_write: assert property ($changed(power_down) |->
		$past(dr_wr) || $past(dr_wr, 2))
		else $error("power-down moved alone");
endmodule : fdr_regs_monitor
`default_nettype wire

// ### tb/fdr_engine_model.sv
// Purpose: Command engine stand-in on the data register stream
// Assumes: Bench pushes result bytes into res_q
// Notes: Released result line toggles so stale data is never trusted
`default_nettype none
module fdr_engine_model (
	input wire logic clk_sys, // Clock
	input wire logic stall, // Hold off command bytes
	input wire logic cmd_valid, // Command byte offered
	input wire logic [7:0] cmd_data, // Command byte
	output logic cmd_ready, // Command byte taken
	output logic result_valid, // Result offered
	output logic [7:0] result_data, // Result byte
	input wire logic result_ready // Result consumed
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] got [$];
	logic [7:0] res_q [$];
	assign cmd_ready = !stall;
	initial result_valid = 1'b0;
	initial result_data = 8'h00;
	// Collect commands, retire a result on the edge that sees the pulse;
	// result lines change only on the edge, like any synchronous driver
	always @(posedge clk_sys) begin
		if (cmd_valid && cmd_ready)
			got.push_back(cmd_data);
		if (result_ready && res_q.size() > 0)
			void'(res_q.pop_front());
		result_valid <= (res_q.size() > 0);
		result_data <= (res_q.size() > 0) ? res_q[0] : ~result_data;
	end
endmodule : fdr_engine_model
`default_nettype wire

// ### tb/test_floppy_ctrl_host_registers.sv
// Purpose: Self-checking bench for the floppy host register bank
// Assumes: APB master tasks, engine model on the command side
// Notes: Waits are bounded; a stuck transfer ends the run
`default_nettype none
module test_floppy_ctrl_host_registers
	import fdr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, err;
	logic result_valid, result_ready, cmd_valid, cmd_ready, cfg_strobe;
	logic cfg_fifo_on, status_load, ready_change_abort, soft_reset, stall;
	logic power_down, reduced_write_current_n, fm_illegal, dma_gate;
	logic precomp_fine_step, fifo_enabled, disk_changed_n, done9;
	logic [7:0] paddr, main_status, result_data, cmd_data, status_value;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] status_index, tape_drive_sel, drive_select;
	logic [2:0] precomp_steps;
	fdr_rate_t xfer_rate;
	int mismatches, num_checks, sr_seen;
	fdr_host_regs fdr_host_regs_i (.clk_sys, .rst_n, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .main_status,
		.disk_changed_n, .result_data, .result_valid, .result_ready,
		.cmd_data, .cmd_valid, .cmd_ready, .cfg_strobe, .cfg_fifo_on,
		.status_load, .status_index, .status_value, .ready_change_abort,
		.soft_reset, .power_down, .reduced_write_current_n, .xfer_rate,
		.fm_illegal, .precomp_steps, .precomp_fine_step, .tape_drive_sel,
		.drive_select, .dma_gate, .fifo_enabled);
	fdr_engine_model fdr_engine_model_i (.clk_sys, .stall, .cmd_valid,
		.cmd_data, .cmd_ready, .result_valid, .result_data, .result_ready);
	task automatic chk(input string what, input logic [7:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h00_0000, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 100);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 100) begin
			mismatches++;
			final_report();
		end
	endtask : apb
	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
		repeat (3) @(posedge clk_sys);
	endtask : wr
	task automatic rchk(input string what, input logic [5:0] idx,
			input logic [7:0] e);
		apb(1'b0, idx, 8'h00);
		chk(what, rd[7:0], e);
		chk("upper", 8'(rd[31:8] != 24'h00_0000), 8'h00);
	endtask : rchk
	task automatic rate_chk(input fdr_rate_t e);
		chk("rate", 8'(xfer_rate), 8'(e));
	endtask : rate_chk
	// Rate codes, precomp codes, last writer wins, tape rate, reset bits
	task automatic t_rates;
		fdr_rate_t er [4] = '{XFER_500K, XFER_300K, XFER_250K, XFER_1M};
		logic [2:0] pc [3] = '{3'h0, 3'h5, 3'h7};
		logic [2:0] ps [3] = '{3'h3, 3'h5, 3'h0};
		for (int c = 0; c < 4; c++) begin
			wr(IDX_MAIN_STAT, 8'(c));
			rate_chk(er[c]);
			chk("rwc", 8'(reduced_write_current_n), 8'(c == 0 || c == 3));
			chk("fm", 8'(fm_illegal), 8'(c == 3));
		end
		for (int i = 0; i < 3; i++) begin
			wr(IDX_MAIN_STAT, {3'h0, pc[i], 2'h0});
			chk("steps", 8'(precomp_steps), 8'(ps[i]));
		end
		wr(IDX_SENSE, 8'h02);
		rate_chk(XFER_250K);
		wr(IDX_MAIN_STAT, 8'h03);
		rate_chk(XFER_1M);
		wr(IDX_LDEV0_RATE, 8'h02);
		wr(IDX_MAIN_STAT, 8'h02);
		rate_chk(XFER_250K);
		wr(IDX_MAIN_STAT, 8'h01);
		rate_chk(XFER_2M);
		chk("fine", 8'(precomp_fine_step), 8'h01);
		chk("steps", 8'(precomp_steps), 8'h01);
		wr(IDX_LDEV0_RATE, 8'h00);
		wr(IDX_MAIN_STAT, 8'hC0);
		chk("swrst", 8'(sr_seen), 8'h01);
		chk("pwrdn", 8'(power_down), 8'h01);
		wr(IDX_MAIN_STAT, 8'h00);
		chk("swrst", 8'(sr_seen), 8'h01);
		chk("pwrdn", 8'(power_down), 8'h00);
	endtask : t_rates
	// Tape register mirrors and drive-type pair selection
	task automatic t_tape;
		wr(IDX_MEDIA_BOOT, 8'h06);
		wr(IDX_DRIVE_TYPE, 8'hE4);
		wr(IDX_DIGITAL_OUT, 8'h0A);
		wr(IDX_TAPE, 8'hFF);
		rchk("tape", IDX_TAPE, 8'h6B);
		chk("tsel", 8'(tape_drive_sel), 8'h03);
		chk("dsel", 8'(drive_select), 8'h02);
		chk("dma", 8'(dma_gate), 8'h01);
		wr(IDX_DIGITAL_OUT, 8'h09);
		wr(IDX_TAPE, 8'h01);
		rchk("tape", IDX_TAPE, 8'h59);
		chk("dsel", 8'(drive_select), 8'h01);
	endtask : t_tape
	// Input sense layouts in the three system modes
	task automatic t_sense;
		wr(IDX_SYS_MODE, 8'h00);
		rchk("sense", IDX_SENSE, 8'h80);
		wr(IDX_SYS_MODE, 8'h01);
		wr(IDX_SENSE, 8'hFE);
		rate_chk(XFER_250K);
		rchk("sense", IDX_SENSE, 8'hFD);
		wr(IDX_SENSE, 8'h03);
		rchk("sense", IDX_SENSE, 8'hFE);
		wr(IDX_SYS_MODE, 8'h02);
		wr(IDX_SENSE, 8'h06);
		rchk("sense", IDX_SENSE, 8'h7E);
		chk("steps", 8'(precomp_steps), 8'h03);
		wr(IDX_SYS_MODE, 8'h00);
		disk_changed_n <= 1'b1;
		rchk("sense", IDX_SENSE, 8'h00);
	endtask : t_sense
	// Status stack, abort code, result byte, FIFO fill and drain
	task automatic t_data;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			status_load <= 1'b1;
			status_index <= 2'(i);
			status_value <= 8'(8'h10 + i);
		end
		@(posedge clk_sys);
		status_load <= 1'b0;
		ready_change_abort <= 1'b1;
		@(posedge clk_sys);
		ready_change_abort <= 1'b0;
		rchk("stack", IDX_FIFO, 8'hD0);
		for (int i = 1; i < 4; i++)
			rchk("stack", IDX_FIFO, 8'(8'h10 + i));
		rchk("wrap", IDX_FIFO, 8'hD0);
		rchk("ptr", IDX_STATUS_VIEW, 8'h01);
		fdr_engine_model_i.res_q.push_back(8'hA5);
		repeat (3) @(posedge clk_sys);
		rchk("result", IDX_FIFO, 8'hA5);
		repeat (2) @(posedge clk_sys);
		chk("taken", 8'(fdr_engine_model_i.res_q.size()), 8'h00);
		rchk("ptr", IDX_STATUS_VIEW, 8'h01);
		@(posedge clk_sys);
		cfg_strobe <= 1'b1;
		cfg_fifo_on <= 1'b1;
		@(posedge clk_sys);
		cfg_strobe <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk("fifo_on", 8'(fifo_enabled), 8'h01);
		stall <= 1'b1;
		for (int i = 0; i < 8; i++)
			apb(1'b1, IDX_FIFO, 8'(8'h30 + i));
		fork
			begin
				apb(1'b1, IDX_FIFO, 8'h38);
				done9 = 1'b1;
			end
			begin
				repeat (20) @(posedge clk_sys);
				chk("full", 8'(done9), 8'h00);
				stall <= 1'b0;
			end
		join
		repeat (15) @(posedge clk_sys);
		chk("count", 8'(fdr_engine_model_i.got.size()), 8'h09);
		foreach (fdr_engine_model_i.got[i])
			chk("cmd", fdr_engine_model_i.got[i], 8'(8'h30 + i));
		wr(IDX_MAIN_STAT, 8'h80);
		chk("fifo_off", 8'(fifo_enabled), 8'h00);
	endtask : t_data
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// Count soft reset pulses; a pulse lasts one cycle
	always @(posedge clk_sys) begin
		if (soft_reset === 1'b1)
			sr_seen++;
	end
	initial begin
		{psel, penable, pwrite, cfg_strobe, cfg_fifo_on, status_load} = '0;
		{ready_change_abort, stall, disk_changed_n, done9, rst_n} = '0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		main_status = 8'h5A;
		status_index = 2'h0;
		status_value = 8'h00;
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		rate_chk(XFER_500K);
		chk("fifo_on", 8'(fifo_enabled), 8'h00);
		rchk("main", IDX_MAIN_STAT, 8'h5A);
		apb(1'b0, 6'h06, 8'h00);
		chk("unmapped", 8'(err), 8'h01);
		t_rates();
		t_tape();
		t_sense();
		t_data();
		final_report();
	end
endmodule : test_floppy_ctrl_host_registers
bind fdr_host_regs fdr_regs_monitor fdr_regs_monitor_i (.clk_sys, .rst_n,
	.psel, .penable, .pwrite, .paddr, .pwdata, .pready, .soft_reset,
	.power_down, .reduced_write_current_n, .xfer_rate, .fm_illegal,
	.precomp_fine_step, .fifo_enabled);
`default_nettype wire
